// ---- rtl/soam_monitor.sv ----
// Quad-port receive overhead alarm, protection byte and label monitor
//
// Notes on behaviour
// - Loss of signal or frame suppresses and clears line RDI and byte failure.
// - Loss of signal, frame or line AIS suppresses and clears loss of pointer.
// - Any line or pointer or path AIS defect clears path RDI/PLM/UNEQ/TIM/TIU.
// - Send line RDI on loss of signal, loss of frame or line AIS.
// - Send path RDI, one-bit or server code, on LOS/LOF/line AIS/path AIS.
// - Enhanced mode: payload code on PLM, connectivity code on UNEQ or TIM.
// - Transmit line REI from B2 errors and path REI from B3 errors.
// - B1 holds on LOS/OOF; B2 on LOS/LOF/AIS; line REI also on RDI.
// - B3 holds on line or path defects; path REI also on path RDI.
// - Cell counters hold on line, path defects or loss of cell delineation.
// - Packet counters hold on line or path defects.
// - Send K1/K2 from transmit register; neither AIS nor RDI insertion overrides.
// - Flag a new K1/K2 value once it persists three frames, in frame only.
// - Received K1/K2 register updates only after three identical frames.
// - Byte failure if no three equal K1 in 12 frames; cleared by three.
// - Each port's cell available passes, registered, to the upstream device.
// - Count C2 changes; unstable at five; reset after n identical labels.
// - Received label register captures C2 after n identical frames.
// - Unequipped after n zero labels, cleared after n others; inhibited.
// - Expected label 13h; 01h matches unless excluded; 00h match optional.
// - Mismatch after n mismatching labels, cleared after n matches; inhibited.
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module soam_monitor
  import soam_pkg::*;
#(
  parameter int NP = soam_pkg::NPORT
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [soam_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // Receive defect flags, per port
  input  wire logic [NP-1:0]         los_i,
  input  wire logic [NP-1:0]         oof_i,
  input  wire logic [NP-1:0]         lof_i,
  input  wire logic [NP-1:0]         line_ais_i,
  input  wire logic [NP-1:0]         line_rdi_raw_i,
  input  wire logic [NP-1:0]         lop_raw_i,
  input  wire logic [NP-1:0]         path_ais_i,
  input  wire logic [NP-1:0]         path_rdi_raw_i,
  input  wire logic [NP-1:0]         path_tim_raw_i,
  input  wire logic [NP-1:0]         path_tiu_raw_i,
  input  wire logic [NP-1:0]         lcd_i,
  input  wire logic [NP-1:0]         b2_err_i,
  input  wire logic [NP-1:0]         b3_err_i,
  input  wire logic [NP-1:0]         cell_avail_i,
  // Received overhead bytes, one strobe per frame
  input  wire logic [NP-1:0]         frame_i,
  input  wire logic [NP*8-1:0]       k1_i,
  input  wire logic [NP*8-1:0]       k2_i,
  input  wire logic [NP*8-1:0]       c2_i,
  // Gated defects
  output logic      [NP-1:0]         line_rdi_o,
  output logic      [NP-1:0]         lop_o,
  output logic      [NP-1:0]         path_rdi_o,
  output logic      [NP-1:0]         path_tim_o,
  output logic      [NP-1:0]         path_tiu_o,
  output logic      [NP-1:0]         psbf_o,
  output logic      [NP-1:0]         uneq_o,
  output logic      [NP-1:0]         plm_o,
  output logic      [NP-1:0]         plu_o,
  // Counter holds
  output logic      [NP-1:0]         hold_b1_o,
  output logic      [NP-1:0]         hold_b2_o,
  output logic      [NP-1:0]         hold_line_rei_o,
  output logic      [NP-1:0]         hold_b3_o,
  output logic      [NP-1:0]         hold_path_rei_o,
  output logic      [NP-1:0]         hold_cell_o,
  output logic      [NP-1:0]         hold_pkt_o,
  // Transmit overhead
  output logic      [NP-1:0]         tx_line_rdi_o,
  output logic      [NP*3-1:0]       tx_path_rdi_o,
  output logic      [NP-1:0]         tx_line_rei_o,
  output logic      [NP-1:0]         tx_path_rei_o,
  output logic      [NP*8-1:0]       tx_k1_o,
  output logic      [NP*8-1:0]       tx_k2_o,
  // Cell available seen by the upstream device
  output logic      [NP-1:0]         cell_avail_o
);
  // ****************************************
  // State
  // ****************************************
  soam_state_t st_ff;
  soam_state_t nxt_st;
  logic [NP-1:0] alarm_ff;
  // Decode port and register from a byte address
  function automatic logic [2:0] soam_reg(input logic [ADDR_W-1:0] a);
    soam_reg = a[4:2];
  endfunction
  function automatic logic [1:0] soam_port(input logic [ADDR_W-1:0] a);
    soam_port = a[6:5];
  endfunction
  // Counter of n identical/condition frames, saturating at the limit
  function automatic logic [3:0] soam_run(input logic [3:0] c,
                                          input logic       same,
                                          input logic [3:0] lim);
    if (!same)
      soam_run = 4'h1;
    else if (c < lim)
      soam_run = c + 4'h1;
    else
      soam_run = lim;
  endfunction
  logic bus_req;
  assign bus_req = wb_cyc_i && wb_stb_i && (st_ff.bus == SOAM_BUS_IDLE);
  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [1:0]  sp;
    logic [2:0]  sr;
    logic [15:0] kk;
    logic [7:0]  c2;
    logic [3:0]  n;
    logic        in_frame;
    logic        path_inh;
    logic        match;
    nxt_st = st_ff;
    sp = soam_port(wb_adr_i);
    sr = soam_reg(wb_adr_i);
    kk = 16'h0000;
    c2 = 8'h00;
    n = CNT_LONG;
    in_frame = 1'b0;
    path_inh = 1'b0;
    match = 1'b0;
    nxt_st.rdata = 32'h0000_0000;
    nxt_st.bus = (bus_req) ? SOAM_BUS_ACK : SOAM_BUS_IDLE;
    for (int p = 0; p < NP; p++) begin
      kk = {k1_i[p*8 +: 8], k2_i[p*8 +: 8]};
      c2 = c2_i[p*8 +: 8];
      in_frame = !(los_i[p] || lof_i[p] || oof_i[p]);
      path_inh = los_i[p] || lof_i[p] || line_ais_i[p] ||
                 lop_raw_i[p] || path_ais_i[p];
      nxt_st.port[p].prot_evt = 1'b0;
      nxt_st.port[p].uneq_evt = 1'b0;
      nxt_st.port[p].plm_evt = 1'b0;
      if (frame_i[p]) begin
        if (in_frame) begin
          nxt_st.port[p].prot_last = kk;
          nxt_st.port[p].prot_run =
            soam_run(st_ff.port[p].prot_run,
                     kk == st_ff.port[p].prot_last, PROT_PERSIST);
          if (nxt_st.port[p].prot_run == PROT_PERSIST &&
              st_ff.port[p].prot_rx != kk) begin
            nxt_st.port[p].prot_rx = kk;
            nxt_st.port[p].prot_evt = 1'b1;
          end
        end
        nxt_st.port[p].k1_last = kk[15:8];
        nxt_st.port[p].k1_run = soam_run(st_ff.port[p].k1_run,
                        kk[15:8] == st_ff.port[p].k1_last, PROT_PERSIST);
        if (nxt_st.port[p].k1_run == PROT_PERSIST)
          nxt_st.port[p].k1_win = 4'h0;
        else if (st_ff.port[p].k1_win < PSBF_WINDOW)
          nxt_st.port[p].k1_win = st_ff.port[p].k1_win + 4'h1;
        if (!line_ais_i[p]) begin
          if (nxt_st.port[p].k1_run == PROT_PERSIST)
            nxt_st.port[p].psbf = 1'b0;
          else if (nxt_st.port[p].k1_win >= PSBF_WINDOW)
            nxt_st.port[p].psbf = 1'b1;
        end
        n = st_ff.port[p].poh_mode[STAB_SEL_BIT] ? CNT_LONG : CNT_SHORT;
        nxt_st.port[p].c2_last = c2;
        nxt_st.port[p].c2_run = soam_run(st_ff.port[p].c2_run,
                                c2 == st_ff.port[p].c2_last, n);
        if (c2 != st_ff.port[p].c2_last) begin
          if (st_ff.port[p].c2_chg < UNSTABLE_LIM)
            nxt_st.port[p].c2_chg = st_ff.port[p].c2_chg + 4'h1;
          if (nxt_st.port[p].c2_chg == UNSTABLE_LIM)
            nxt_st.port[p].plu = 1'b1;
        end else if (nxt_st.port[p].c2_run == n) begin
          nxt_st.port[p].c2_chg = 4'h0;
          nxt_st.port[p].plu = 1'b0;
          nxt_st.port[p].label_rx = c2;
        end
        n = st_ff.port[p].poh_mode[UNEQ_SEL_BIT] ? CNT_LONG : CNT_SHORT;
        if ((c2 == LABEL_UNEQ) != st_ff.port[p].uneq)
          nxt_st.port[p].uneq_cnt = st_ff.port[p].uneq_cnt + 4'h1;
        else
          nxt_st.port[p].uneq_cnt = 4'h0;
        if (nxt_st.port[p].uneq_cnt >= n) begin
          nxt_st.port[p].uneq = !st_ff.port[p].uneq;
          nxt_st.port[p].uneq_evt = !st_ff.port[p].uneq;
          nxt_st.port[p].uneq_cnt = 4'h0;
        end
        if (c2 == st_ff.port[p].poh_mode[EXP_LSB +: 8])
          match = 1'b1;
        else if (c2 == LABEL_ONE)
          match = !st_ff.port[p].poh_mode[ONE_EXCL_BIT];
        else if (c2 == LABEL_UNEQ)
          match = st_ff.port[p].poh_mode[ZERO_ACC_BIT];
        else
          match = 1'b0;
        n = st_ff.port[p].poh_mode[MISM_SEL_BIT] ? CNT_LONG : CNT_SHORT;
        if (match == st_ff.port[p].plm)
          nxt_st.port[p].plm_cnt = st_ff.port[p].plm_cnt + 4'h1;
        else
          nxt_st.port[p].plm_cnt = 4'h0;
        if (nxt_st.port[p].plm_cnt >= n) begin
          nxt_st.port[p].plm = !st_ff.port[p].plm;
          nxt_st.port[p].plm_evt = !st_ff.port[p].plm;
          nxt_st.port[p].plm_cnt = 4'h0;
        end
      end
      if (los_i[p] || lof_i[p]) begin
        nxt_st.port[p].psbf = 1'b0;
        nxt_st.port[p].k1_win = 4'h0;
      end
      if (path_inh) begin
        nxt_st.port[p].uneq = 1'b0;
        nxt_st.port[p].uneq_cnt = 4'h0;
        nxt_st.port[p].uneq_evt = 1'b0;
        nxt_st.port[p].plm = 1'b0;
        nxt_st.port[p].plm_cnt = 4'h0;
        nxt_st.port[p].plm_evt = 1'b0;
      end
    end
    // Register write; event bit 2 is sticky, write one to clear
    if (bus_req && wb_we_i && !wb_adr_i[7]) begin
      unique case ({3'h0, sr, 2'b00})
        OFF_PATH_OVERHEAD: begin
          if (wb_sel_i[0])
            nxt_st.port[sp].poh_mode[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1])
            nxt_st.port[sp].poh_mode[13:8] = wb_dat_i[13:8];
        end
        OFF_PROT_TX: begin
          if (wb_sel_i[0])
            nxt_st.port[sp].prot_tx[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1])
            nxt_st.port[sp].prot_tx[15:8] = wb_dat_i[15:8];
        end
        default: ;
      endcase
    end
    // Register read
    if (bus_req && !wb_we_i && !wb_adr_i[7]) begin
      unique case ({3'h0, sr, 2'b00})
        OFF_ALARM_IN:
          nxt_st.rdata = {25'h0, lcd_i[sp], path_ais_i[sp], lop_raw_i[sp],
                          line_ais_i[sp], lof_i[sp], oof_i[sp], los_i[sp]};
        OFF_PATH_OVERHEAD:
          nxt_st.rdata = {18'h0, st_ff.port[sp].poh_mode};
        OFF_PROT_TX:
          nxt_st.rdata = {16'h0, st_ff.port[sp].prot_tx};
        OFF_PROT_RX:
          nxt_st.rdata = {16'h0, st_ff.port[sp].prot_rx};
        OFF_LABEL_RX:
          nxt_st.rdata = {24'h0, st_ff.port[sp].label_rx};
        OFF_STATUS:
          nxt_st.rdata = {28'h0, st_ff.port[sp].plu, st_ff.port[sp].plm,
                          st_ff.port[sp].uneq, st_ff.port[sp].psbf};
        OFF_EVENT:
          nxt_st.rdata = {29'h0, alarm_ff[sp], st_ff.port[sp].plm,
                          st_ff.port[sp].uneq};
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff.bus <= SOAM_BUS_IDLE;
      st_ff.rdata <= 32'h0000_0000;
      for (int p = 0; p < NP; p++) begin
        st_ff.port[p] <= '0;
        st_ff.port[p].poh_mode <= POH_MODE_RST;
      end
    end else begin
      st_ff <= nxt_st;
    end
  end
  // ****************************************
  // Per-port outputs
  // ****************************************
  // replicated per port
  for (genvar g = 0; g < NP; g++) begin : g_port
    logic lline;
    logic lpath;
    logic path_inh;
    logic line_rdi_g;
    logic path_rdi_g;
    logic enh;
    logic [2:0] rdi_code;
    assign lline = los_i[g] || lof_i[g] || line_ais_i[g];
    assign lpath = lline || lop_raw_i[g] || path_ais_i[g];
    assign path_inh = lpath;
    assign enh = st_ff.port[g].poh_mode[ENH_RDI_BIT];
    assign line_rdi_g = line_rdi_raw_i[g] && !(los_i[g] || lof_i[g]);
    assign path_rdi_g = path_rdi_raw_i[g] && !path_inh;
    always_comb begin
      if (lline || path_ais_i[g])
        rdi_code = enh ? RDI_SERVER : RDI_ONEBIT;
      else if (enh && st_ff.port[g].plm)
        rdi_code = RDI_PAYLOAD;
      else if (enh && (st_ff.port[g].uneq ||
               (path_tim_raw_i[g] && !path_inh)))
        rdi_code = RDI_CONNECT;
      else
        rdi_code = enh ? RDI_NONE : 3'h0;
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        line_rdi_o[g] <= 1'b0;
        lop_o[g] <= 1'b0;
        path_rdi_o[g] <= 1'b0;
        path_tim_o[g] <= 1'b0;
        path_tiu_o[g] <= 1'b0;
        hold_b1_o[g] <= 1'b0;
        hold_b2_o[g] <= 1'b0;
        hold_line_rei_o[g] <= 1'b0;
        hold_b3_o[g] <= 1'b0;
        hold_path_rei_o[g] <= 1'b0;
        hold_cell_o[g] <= 1'b0;
        hold_pkt_o[g] <= 1'b0;
        tx_line_rdi_o[g] <= 1'b0;
        tx_path_rdi_o[g*3 +: 3] <= 3'h0;
        tx_line_rei_o[g] <= 1'b0;
        tx_path_rei_o[g] <= 1'b0;
        tx_k1_o[g*8 +: 8] <= 8'h00;
        tx_k2_o[g*8 +: 8] <= 8'h00;
        cell_avail_o[g] <= 1'b0;
        alarm_ff[g] <= 1'b0;
      end else begin
        line_rdi_o[g] <= line_rdi_g;
        lop_o[g] <= lop_raw_i[g] && !lline;
        path_rdi_o[g] <= path_rdi_g;
        path_tim_o[g] <= path_tim_raw_i[g] && !path_inh;
        path_tiu_o[g] <= path_tiu_raw_i[g] && !path_inh;
        hold_b1_o[g] <= los_i[g] || oof_i[g];
        hold_b2_o[g] <= lline;
        hold_line_rei_o[g] <= lline || line_rdi_g;
        hold_b3_o[g] <= lpath;
        hold_path_rei_o[g] <= lpath || path_rdi_g;
        hold_cell_o[g] <= lpath || lcd_i[g];
        hold_pkt_o[g] <= lpath;
        tx_line_rdi_o[g] <= lline;
        tx_path_rdi_o[g*3 +: 3] <= rdi_code;
        tx_line_rei_o[g] <= b2_err_i[g];
        tx_path_rei_o[g] <= b3_err_i[g];
        tx_k1_o[g*8 +: 8] <= st_ff.port[g].prot_tx[15:8];
        tx_k2_o[g*8 +: 8] <= st_ff.port[g].prot_tx[7:0];
        cell_avail_o[g] <= cell_avail_i[g];
        // Sticky event: set wins over a clear in the same cycle
        if (st_ff.port[g].prot_evt || st_ff.port[g].uneq_evt ||
            st_ff.port[g].plm_evt)
          alarm_ff[g] <= 1'b1;
        else if (bus_req && wb_we_i && !wb_adr_i[7] &&
                 soam_port(wb_adr_i) == 2'(g) &&
                 {3'h0, soam_reg(wb_adr_i), 2'b00} == OFF_EVENT &&
                 wb_sel_i[0] && wb_dat_i[2])
          alarm_ff[g] <= 1'b0;
      end
    end
    assign psbf_o[g] = st_ff.port[g].psbf;
    assign uneq_o[g] = st_ff.port[g].uneq;
    assign plm_o[g] = st_ff.port[g].plm;
    assign plu_o[g] = st_ff.port[g].plu;
  end
  assign wb_ack_o = st_ff.bus[1];
  assign wb_dat_o = st_ff.rdata;
endmodule

// ---- rtl/soam_pkg.sv ----
// Package: constants, register map and state layout for the alarm monitor
package soam_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NPORT      = 4;
  localparam int ADDR_W     = 8;

  // ****************************************
  // Register byte offsets (port p at PORT_STRIDE*p)
  // ****************************************
  localparam logic [7:0] PORT_STRIDE          = 8'h20;
  localparam logic [7:0] OFF_ALARM_IN         = 8'h00;
  localparam logic [7:0] OFF_PATH_OVERHEAD    = 8'h04;
  localparam logic [7:0] OFF_PROT_TX          = 8'h08;
  localparam logic [7:0] OFF_PROT_RX          = 8'h0C;
  localparam logic [7:0] OFF_LABEL_RX         = 8'h10;
  localparam logic [7:0] OFF_STATUS           = 8'h14;
  localparam logic [7:0] OFF_EVENT            = 8'h18;

  // ****************************************
  // Field positions of path_overhead_mode_reg
  // ****************************************
  localparam int EXP_LSB        = 0;
  localparam int ZERO_ACC_BIT   = 8;
  localparam int ONE_EXCL_BIT   = 9;
  localparam int MISM_SEL_BIT   = 10;
  localparam int UNEQ_SEL_BIT   = 11;
  localparam int STAB_SEL_BIT   = 12;
  localparam int ENH_RDI_BIT    = 13;

  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [7:0]  EXP_LABEL_RST = 8'h13;
  localparam logic [13:0] POH_MODE_RST  = 14'h1C13;
  localparam logic [7:0]  LABEL_UNEQ    = 8'h00;
  localparam logic [7:0]  LABEL_ONE     = 8'h01;
  localparam logic [3:0]  CNT_SHORT     = 4'h3;
  localparam logic [3:0]  CNT_LONG      = 4'h5;
  localparam logic [3:0]  PROT_PERSIST  = 4'h3;
  localparam logic [3:0]  PSBF_WINDOW   = 4'hC;
  localparam logic [3:0]  UNSTABLE_LIM  = 4'h5;

  // Path RDI codes, enhanced and one-bit (G1 bits 5..7)
  localparam logic [2:0] RDI_NONE    = 3'h1;
  localparam logic [2:0] RDI_SERVER  = 3'h5;
  localparam logic [2:0] RDI_CONNECT = 3'h6;
  localparam logic [2:0] RDI_PAYLOAD = 3'h2;
  localparam logic [2:0] RDI_ONEBIT  = 3'h4;

  // Wishbone slave phases
  typedef enum logic [1:0] {
    SOAM_BUS_IDLE = 2'b01,
    SOAM_BUS_ACK  = 2'b10
  } soam_bus_t;

  // Per-port monitor state
  typedef struct packed {
    logic [13:0] poh_mode;
    logic [15:0] prot_tx;
    logic [15:0] prot_rx;
    logic [15:0] prot_last;
    logic [3:0]  prot_run;
    logic        prot_evt;
    logic [7:0]  k1_last;
    logic [3:0]  k1_run;
    logic [3:0]  k1_win;
    logic        psbf;
    logic [7:0]  c2_last;
    logic [3:0]  c2_run;
    logic [3:0]  c2_chg;
    logic        plu;
    logic [7:0]  label_rx;
    logic [3:0]  uneq_cnt;
    logic        uneq;
    logic [3:0]  plm_cnt;
    logic        plm;
    logic        uneq_evt;
    logic        plm_evt;
  } soam_port_t;

  typedef struct packed {
    soam_bus_t   bus;
    logic [31:0] rdata;
    soam_port_t [NPORT-1:0] port;
  } soam_state_t;

endpackage

// ---- verif/soam_monitor_sva.sv ----
// Checker: defect gating, transmit alarms and counter holds
`timescale 1ns/1ps
module soam_monitor_sva #(
  parameter int NP = 4
) (
  // Clock and reset
  input wire logic          clk_i,
  input wire logic          rst_i,
  // Receive defects
  input wire logic [NP-1:0] los_i,
  input wire logic [NP-1:0] oof_i,
  input wire logic [NP-1:0] lof_i,
  input wire logic [NP-1:0] line_ais_i,
  input wire logic [NP-1:0] line_rdi_raw_i,
  input wire logic [NP-1:0] lop_raw_i,
  input wire logic [NP-1:0] path_ais_i,
  input wire logic [NP-1:0] path_rdi_raw_i,
  input wire logic [NP-1:0] path_tim_raw_i,
  input wire logic [NP-1:0] path_tiu_raw_i,
  input wire logic [NP-1:0] lcd_i,
  input wire logic [NP-1:0] b2_err_i,
  input wire logic [NP-1:0] b3_err_i,
  input wire logic [NP-1:0] cell_avail_i,
  // Monitor outputs
  input wire logic [NP-1:0] line_rdi_o,
  input wire logic [NP-1:0] lop_o,
  input wire logic [NP-1:0] path_rdi_o,
  input wire logic [NP-1:0] path_tim_o,
  input wire logic [NP-1:0] path_tiu_o,
  input wire logic [NP-1:0] uneq_o,
  input wire logic [NP-1:0] plm_o,
  input wire logic [NP-1:0] hold_b1_o,
  input wire logic [NP-1:0] hold_b2_o,
  input wire logic [NP-1:0] hold_line_rei_o,
  input wire logic [NP-1:0] hold_b3_o,
  input wire logic [NP-1:0] hold_path_rei_o,
  input wire logic [NP-1:0] hold_cell_o,
  input wire logic [NP-1:0] hold_pkt_o,
  input wire logic [NP-1:0] tx_line_rdi_o,
  input wire logic [NP-1:0] tx_line_rei_o,
  input wire logic [NP-1:0] tx_path_rei_o,
  input wire logic [NP-1:0] cell_avail_o
);
  // Line-level and path-level defect unions
  wire logic [NP-1:0] ld = los_i | lof_i | line_ais_i;
  wire logic [NP-1:0] pd = ld | lop_raw_i | path_ais_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****************
  // Steps
  // ****************
  sequence s_line_def;
    |ld;
  endsequence
  sequence s_rdi_sent;
    ##1 (tx_line_rdi_o == $past(ld));
  endsequence
  // ****************
  // Properties
  // ****************
  a_line_rdi_gate: assert property (
    line_rdi_o == $past(line_rdi_raw_i & ~(los_i | lof_i)))
    else $error("line rdi not gated by los or lof");
  a_lop_gate: assert property (
    lop_o == $past(lop_raw_i & ~ld)) else $error("lop gating wrong");
  a_label_inhibit: assert property (
    ((uneq_o | plm_o) & $past(pd)) == '0)
    else $error("label alarm present under path defect");
  a_line_rdi_tx: assert property (s_line_def |-> s_rdi_sent)
    else $error("line rdi not transmitted");
  a_rei_copy: assert property (
    {tx_line_rei_o, tx_path_rei_o} == $past({b2_err_i, b3_err_i}))
    else $error("rei does not follow parity errors");
  a_b1_hold: assert property (hold_b1_o == $past(los_i | oof_i))
    else $error("b1 hold wrong");
  a_b3_hold: assert property (hold_b3_o == $past(pd))
    else $error("b3 hold wrong");
  a_cell_hold: assert property (hold_cell_o == $past(pd | lcd_i))
    else $error("cell hold wrong");
  a_path_gate: assert property (
    {path_rdi_o, path_tim_o, path_tiu_o} == $past({3{~pd}} &
    {path_rdi_raw_i, path_tim_raw_i, path_tiu_raw_i}))
    else $error("path defect not gated");
  a_line_holds: assert property (
    {hold_b2_o, hold_line_rei_o} == $past({ld, ld | line_rdi_raw_i}))
    else $error("line holds wrong");
  a_path_holds: assert property (
    {hold_path_rei_o, hold_pkt_o} == $past({pd | path_rdi_raw_i, pd}))
    else $error("path holds wrong");
  a_cell_avail: assert property (cell_avail_o == $past(cell_avail_i))
    else $error("cell available not passed");
endmodule

bind soam_monitor soam_monitor_sva #(.NP(NP)) soam_monitor_sva_inst (
  .clk_i, .rst_i, .los_i, .oof_i, .lof_i, .line_ais_i, .line_rdi_raw_i,
  .lop_raw_i, .path_ais_i, .path_rdi_raw_i, .path_tim_raw_i,
  .path_tiu_raw_i, .lcd_i, .b2_err_i, .b3_err_i, .cell_avail_i,
  .line_rdi_o, .lop_o, .path_rdi_o, .path_tim_o, .path_tiu_o, .uneq_o,
  .plm_o, .hold_b1_o, .hold_b2_o, .hold_line_rei_o, .hold_b3_o,
  .hold_path_rei_o, .hold_cell_o, .hold_pkt_o, .tx_line_rdi_o,
  .tx_line_rei_o, .tx_path_rei_o, .cell_avail_o
);

// ---- verif/soam_framer_model.sv ----
// Receive framer model: overhead bytes of port 0 with a frame strobe
`timescale 1ns/1ps
module soam_framer_model (
  // Clock
  input  wire logic        clk_i,
  // Overhead towards the monitor
  output logic      [3:0]  frame_o,
  output logic      [31:0] k1_o,
  output logic      [31:0] k2_o,
  output logic      [31:0] c2_o
);
  initial begin
    frame_o = 4'h0;
    k1_o = 32'h0000_0000;
    k2_o = 32'h0000_0000;
    c2_o = 32'h0000_0000;
  end
  // Bytes are inverted off the strobe so a late sample never matches
  task automatic send(input logic [7:0] k1, k2, c2);
    frame_o[0] <= 1'b1;
    k1_o[7:0] <= k1;
    k2_o[7:0] <= k2;
    c2_o[7:0] <= c2;
    @(posedge clk_i);
    frame_o[0] <= 1'b0;
    k1_o[7:0] <= ~k1;
    k2_o[7:0] <= ~k2;
    c2_o[7:0] <= ~c2;
    repeat (3) @(posedge clk_i);
  endtask
endmodule

// ---- verif/tb_soam_monitor.sv ----
// Self-checking bench for the quad alarm monitor
`timescale 1ns/1ps
module tb_soam_monitor;
  import soam_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0]  dv [14];
  logic [3:0]  frm, psbf, uneq, plm, plu;
  logic [31:0] k1, k2, c2, dat_o, tk1, tk2;
  logic [11:0] prdi;
  logic        ack;
  int          err_count = 0;
  int          checks_done = 0;
  always #4 clk_i = ~clk_i;
  soam_framer_model fm (.clk_i, .frame_o(frm), .k1_o(k1), .k2_o(k2),
    .c2_o(c2));
  soam_monitor soam_monitor_inst (
    .clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .los_i(dv[0]), .oof_i(dv[1]), .lof_i(dv[2]),
    .line_ais_i(dv[3]), .line_rdi_raw_i(dv[4]), .lop_raw_i(dv[5]),
    .path_ais_i(dv[6]), .path_rdi_raw_i(dv[7]), .path_tim_raw_i(dv[8]),
    .path_tiu_raw_i(dv[9]), .lcd_i(dv[10]), .b2_err_i(dv[11]),
    .b3_err_i(dv[12]), .cell_avail_i(dv[13]), .frame_i(frm), .k1_i(k1),
    .k2_i(k2), .c2_i(c2), .line_rdi_o(), .lop_o(), .path_rdi_o(),
    .path_tim_o(), .path_tiu_o(), .psbf_o(psbf), .uneq_o(uneq),
    .plm_o(plm), .plu_o(plu), .hold_b1_o(), .hold_b2_o(),
    .hold_line_rei_o(), .hold_b3_o(), .hold_path_rei_o(), .hold_cell_o(),
    .hold_pkt_o(), .tx_line_rdi_o(), .tx_path_rdi_o(prdi),
    .tx_line_rei_o(), .tx_path_rei_o(), .tx_k1_o(tk1), .tx_k2_o(tk2),
    .cell_avail_o()
  );
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic cycle: held until ack is sampled, then one idle cycle
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 16);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      chk("bus ack", 32'h1, 32'(ack));
      tally_and_finish();
    end
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    logic [31:0] q;
    xfer(a, 1'b0, 32'h0000_0000, q);
    chk(nm, e, q);
  endtask
  task automatic cf(input logic [7:0] c2v, input int n);
    repeat (n) fm.send(8'h77, 8'h34, c2v);
  endtask
  initial begin
    foreach (dv[i]) dv[i] = 4'h0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rc("mode", OFF_PATH_OVERHEAD, {18'h0, POH_MODE_RST});
    rc("unmapped", 8'h80, 32'h0000_0000);
    wr(OFF_PROT_TX, 32'h0000_A55A);
    wr(8'h88, 32'h0000_FFFF);
    rc("prot tx", OFF_PROT_TX, 32'h0000_A55A);
    chk("tx k", 32'h0000_A55A, {16'h0, tk1[7:0], tk2[7:0]});
    repeat (3) fm.send(8'h12, 8'h34, 8'h13);
    rc("prot rx", OFF_PROT_RX, 32'h0000_1234);
    rc("event", OFF_EVENT, 32'h0000_0004);
    wr(OFF_EVENT, 32'h0000_0004);
    repeat (3) fm.send(8'h12, 8'h34, 8'h13);
    rc("event rpt", OFF_EVENT, 32'h0000_0000);
    for (int i = 0; i < 12; i++) fm.send(8'(i + 1), 8'h34, 8'h13);
    chk("psbf set", 32'h1, 32'(psbf));
    rc("prot hold", OFF_PROT_RX, 32'h0000_1234);
    repeat (3) fm.send(8'h66, 8'h34, 8'h13);
    chk("psbf clr", 32'h0, 32'(psbf));
    cf(8'h00, 4);
    chk("uneq plm 4", 32'h00, 32'({uneq, plm}));
    cf(8'h00, 1);
    chk("uneq plm 5", 32'h11, 32'({uneq, plm}));
    rc("label 00", OFF_LABEL_RX, 32'h0000_0000);
    cf(8'h01, 5);
    chk("one match", 32'h00, 32'({uneq, plm}));
    wr(OFF_PATH_OVERHEAD, 32'h0000_1E13);
    cf(8'h01, 5);
    chk("one excl", 32'h1, 32'(plm));
    wr(OFF_PATH_OVERHEAD, 32'h0000_1D13);
    cf(8'h00, 5);
    chk("zero acc", 32'h10, 32'({uneq, plm}));
    wr(OFF_PATH_OVERHEAD, 32'h0000_1813);
    cf(8'h55, 2);
    chk("plm n3 2", 32'h0, 32'(plm));
    cf(8'h55, 3);
    chk("plm n3 3", 32'h1, 32'(plm));
    wr(OFF_PATH_OVERHEAD, 32'h0000_3813);
    repeat (2) @(posedge clk_i);
    chk("rdi pay", 32'(RDI_PAYLOAD), 32'(prdi[2:0]));
    dv[0] <= 4'h1;
    repeat (3) @(posedge clk_i);
    chk("rdi srv", 32'(RDI_SERVER), 32'(prdi[2:0]));
    chk("plm los", 32'h0, 32'(plm));
    dv[0] <= 4'h0;
    dv[8] <= 4'h1;
    repeat (3) @(posedge clk_i);
    chk("rdi con", 32'(RDI_CONNECT), 32'(prdi[2:0]));
    dv[8] <= 4'h0;
    repeat (3) @(posedge clk_i);
    chk("rdi none", 32'(RDI_NONE), 32'(prdi[2:0]));
    wr(OFF_PATH_OVERHEAD, {18'h0, POH_MODE_RST});
    dv[0] <= 4'h1;
    repeat (3) @(posedge clk_i);
    chk("rdi one", 32'(RDI_ONEBIT), 32'(prdi[2:0]));
    dv[0] <= 4'h0;
    cf(8'h13, 5);
    for (int i = 0; i < 5; i++) begin
      if (i == 4) chk("plu 4", 32'h0, 32'(plu));
      cf(i[0] ? 8'h13 : 8'h14, 1);
    end
    chk("plu 5", 32'h1, 32'(plu));
    cf(8'h14, 5);
    chk("plu clr", 32'h0, 32'(plu));
    rc("label 14", OFF_LABEL_RX, 32'h0000_0014);
    for (int i = 0; i < 14; i++) begin
      dv[i] <= 4'h9;
      repeat (3) @(posedge clk_i);
      dv[i] <= 4'h0;
      @(posedge clk_i);
    end
    tally_and_finish();
  end
endmodule
